// ---- logic/cap_sense_timer_base.sv ----
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - t0 sense select with t0 source clear
// - t1 source field 11 selects sense
// - t1 off, free, or gated by enable
// - one count per sense oscillator cycle
module cap_sense_timer_base
    import cap_sense_pkg::*;
#(
    parameter int unsigned timer_width = cap_sense_pkg::timer_width_default,
    parameter int unsigned timer0_width = cap_sense_pkg::timer0_width_default
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic sense_osc_i,
    input wire logic timer0_other_tick_i,
    input wire logic timer1_other_tick_i,
    input wire logic timer1_gate_i,
    input wire logic [cap_sense_pkg::addr_width-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o
);
    import cap_sense_pkg::*;

    logic [31:0] ctrl0_q;
    logic [31:0] t1ctrl_q;
    logic [event_count-1:0] status_q;
    logic [event_count-1:0] mask_q;
    logic sense_q;
    logic gate_ff_q;
    logic [31:0] readdata_q;
    logic ack_q;
    logic sense_rise;
    logic t0_sense;
    logic t1_sense;
    logic t0_tick;
    logic t1_tick;
    logic t1_run;
    logic t1_gate_en;
    logic t1_toggle;
    logic t1_count_en;
    logic gate_event;
    logic [timer0_width-1:0] t0_count;
    logic [timer_width-1:0] t1_count;
    logic t0_ovf;
    logic t1_ovf;
    logic window_close;
    logic bus_wr;
    logic [event_count-1:0] ev;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // input sampled synchronous; edge counted once per oscillator cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sense_q <= 1'b0;
        end else begin
            sense_q <= sense_osc_i;
        end
    end
    assign sense_rise = sense_osc_i && !sense_q;

    assign t0_sense = ctrl0_q[sense_to_timer0_select_bit] && !ctrl0_q[timer0_clock_source_select_bit];
    assign t1_sense = t1ctrl_q[timer1_clock_source_lo +: 2] == timer1_source_cap_sense;
    assign t0_tick = t0_sense ? sense_rise : timer0_other_tick_i;
    assign t1_run = t1ctrl_q[timer1_run_bit_pos];
    assign t1_gate_en = t1ctrl_q[timer1_gate_enable_pos];
    assign t1_toggle = t1ctrl_q[timer1_gate_toggle_pos];

    // gate source is t0 overflow or the external gate pin
    assign gate_event = t1_toggle ? t0_ovf : timer1_gate_i;

    // run bit clear also clears the gate flip-flop
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gate_ff_q <= 1'b0;
        end else if (!t1_run) begin
            gate_ff_q <= 1'b0;
        end else if (t1_toggle && gate_event) begin
            gate_ff_q <= !gate_ff_q;
        end
    end

    assign t1_count_en = t1_run && (!t1_gate_en || (t1_toggle ? gate_ff_q : timer1_gate_i));
    assign t1_tick = t1_count_en && (t1_sense ? sense_rise : timer1_other_tick_i);
    assign window_close = t1_run && t1_gate_en && t1_toggle && gate_ff_q && t0_ovf;

    assign bus_wr = avs_write_i && !ack_q;

    sense_edge_counter #(.width(timer0_width)) u_t0 (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tick_i(t0_tick),
        .load_i(bus_wr && avs_address_i == t0count_offset),
        .load_value_i(avs_writedata_i[timer0_width-1:0]),
        .count_o(t0_count),
        .overflow_o(t0_ovf)
    );

    // software clears the counter at window start by writing zero
    sense_edge_counter #(.width(timer_width)) u_t1 (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tick_i(t1_tick),
        .load_i(bus_wr && avs_address_i == t1count_offset),
        .load_value_i(avs_writedata_i[timer_width-1:0]),
        .count_o(t1_count),
        .overflow_o(t1_ovf)
    );

    // one wait cycle per access keeps read data registered
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl0_q <= ctrl0_reset;
            t1ctrl_q <= t1ctrl_reset;
            mask_q <= '0;
        end else if (bus_wr) begin
            case (avs_address_i)
                ctrl0_offset: begin
                    ctrl0_q <= merge(ctrl0_q, avs_writedata_i, avs_byteenable_i) & 32'h0000_0003;
                    if (avs_byteenable_i[3]) begin
                        mask_q <= avs_writedata_i[int_mask_pos +: event_count];
                    end
                end
                t1ctrl_offset: t1ctrl_q <= merge(t1ctrl_q, avs_writedata_i, avs_byteenable_i) & 32'h0000_00C7;
                default: begin
                end
            endcase
        end
    end

    assign ev[ev_t0_overflow] = t0_ovf;
    assign ev[ev_t1_overflow] = t1_ovf;
    assign ev[ev_window_close] = window_close;

    // set wins over write-one-to-clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_q <= '0;
        end else begin
            for (int i = 0; i < event_count; i++) begin
                if (ev[i]) begin
                    status_q[i] <= 1'b1;
                end else if (bus_wr && avs_address_i == ctrl0_offset && avs_byteenable_i[2]
                             && avs_writedata_i[status_pos + i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_q & mask_q);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            readdata_q <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            case (avs_address_i)
                ctrl0_offset: begin
                    readdata_q <= ctrl0_q;
                    readdata_q[status_pos +: event_count] <= status_q;
                    readdata_q[int_mask_pos +: event_count] <= mask_q;
                end
                t1ctrl_offset: readdata_q <= t1ctrl_q | {28'h0, gate_ff_q, 3'h0};
                t0count_offset: readdata_q <= 32'(t0_count);
                t1count_offset: readdata_q <= 32'(t1_count);
                default: readdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata_o = readdata_q;

    property p_t1_off;
        @(posedge sys_clk_i) disable iff (rst_i)
        !t1_run |=> $stable(t1_count) || $past(bus_wr);
    endproperty
    a_t1_off: assert property (p_t1_off) else $error("timer1 counted while stopped");

    property p_t1_sense_count;
        @(posedge sys_clk_i) disable iff (rst_i)
        (t1_sense && t1_run && !t1_gate_en && sense_rise && !bus_wr && !(&t1_count))
            |=> t1_count == $past(t1_count) + 1'b1;
    endproperty
    a_t1_sense_count: assert property (p_t1_sense_count) else $error("timer1 missed sense edge");

    property p_t0_sense;
        @(posedge sys_clk_i) disable iff (rst_i)
        (t0_sense && !sense_rise && !bus_wr) |=> $stable(t0_count);
    endproperty
    a_t0_sense: assert property (p_t0_sense) else $error("timer0 moved without sense edge");

    sequence s_gate_open;
        t1_run && t1_toggle && !gate_ff_q && t0_ovf;
    endsequence
    property p_toggle;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_gate_open |=> gate_ff_q || !t1_run;
    endproperty
    a_toggle: assert property (p_toggle) else $error("gate toggle did not open");

    property p_gated_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        (t1_run && t1_gate_en && !t1_toggle && !timer1_gate_i && !bus_wr) |=> $stable(t1_count);
    endproperty
    a_gated_hold: assert property (p_gated_hold) else $error("timer1 counted with gate closed");

    // sense-sourced timer1 may only move on a sense rising edge
    property p_one_per_cycle;
        @(posedge sys_clk_i) disable iff (rst_i)
        (t1_sense && !sense_rise && !bus_wr) |=> $stable(t1_count);
    endproperty
    a_one_per_cycle: assert property (p_one_per_cycle) else $error("double sense edge");

    property p_window_flag;
        @(posedge sys_clk_i) disable iff (rst_i)
        window_close |=> status_q[ev_window_close];
    endproperty
    a_window_flag: assert property (p_window_flag) else $error("window close not flagged");

    property p_irq;
        @(posedge sys_clk_i) disable iff (rst_i)
        |(status_q & mask_q) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// ---- logic/cap_sense_pkg.sv ----
package cap_sense_pkg;
    localparam int unsigned addr_width = 4;
    // byte offsets
    localparam logic [addr_width-1:0] ctrl0_offset = 4'h0;
    localparam logic [addr_width-1:0] t1ctrl_offset = 4'h4;
    localparam logic [addr_width-1:0] t0count_offset = 4'h8;
    localparam logic [addr_width-1:0] t1count_offset = 4'hC;
    // status and mask share one word, status in byte 2 and mask in byte 3
    localparam logic [addr_width-1:0] status_offset_hi = 4'h0;
    // cap_sense_control0 fields
    localparam int unsigned sense_to_timer0_select_bit = 0;
    localparam int unsigned timer0_clock_source_select_bit = 1;
    localparam int unsigned mask_lo_bit = 8;
    // timer1_control_register fields
    localparam int unsigned timer1_run_bit_pos = 0;
    localparam int unsigned timer1_gate_enable_pos = 1;
    localparam int unsigned timer1_gate_toggle_pos = 2;
    localparam int unsigned timer1_clock_source_lo = 6;
    localparam logic [1:0] timer1_source_cap_sense = 2'h3;
    localparam logic [31:0] ctrl0_reset = 32'h0000_0000;
    localparam logic [31:0] t1ctrl_reset = 32'h0000_0000;
    localparam int unsigned timer_width_default = 16;
    localparam int unsigned timer0_width_default = 8;
    localparam int unsigned event_count = 3;
    // status bits
    localparam int unsigned ev_t0_overflow = 0;
    localparam int unsigned ev_t1_overflow = 1;
    localparam int unsigned ev_window_close = 2;
    localparam int unsigned status_pos = 16;
    localparam int unsigned int_mask_pos = 24;
endpackage

// ---- logic/sense_edge_counter.sv ----
`timescale 1ns/1ps
module sense_edge_counter #(
    parameter int unsigned width = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic [width-1:0] load_value_i,
    output logic [width-1:0] count_o,
    output logic overflow_o
);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else if (load_i) begin
            count_o <= load_value_i;
        end else if (tick_i) begin
            count_o <= count_o + 1'b1;
        end
    end

    assign overflow_o = tick_i && !load_i && (&count_o);
endmodule

// ---- verification/sense_osc_model.sv ----
`timescale 1ns/1ps
module sense_osc_model (
    input wire logic sys_clk_i,
    output logic sense_osc_o
);
    // pad oscillator is gated off between bursts, so it rests low
    initial sense_osc_o = 1'b0;
    // added pad load shows up as a larger half period
    task automatic burst(input int pulses, input int half);
        for (int p = 0; p < pulses; p++) begin
            repeat (half) @(posedge sys_clk_i);
            sense_osc_o <= 1'b1;
            repeat (half) @(posedge sys_clk_i);
            sense_osc_o <= 1'b0;
        end
    endtask
endmodule

// ---- verification/cap_sense_timer_base_tb.sv ----
`timescale 1ns/1ps
module cap_sense_timer_base_tb;
    import cap_sense_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic osc_w;
    logic t0_tick = 1'b0;
    logic t1_tick = 1'b0;
    logic gate = 1'b0;
    logic [addr_width-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic waitreq;
    logic irq;
    logic [31:0] got;
    logic [31:0] nominal;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    sense_osc_model osc (.sys_clk_i(sys_clk_i), .sense_osc_o(osc_w));
    cap_sense_timer_base dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sense_osc_i(osc_w),
        .timer0_other_tick_i(t0_tick), .timer1_other_tick_i(t1_tick), .timer1_gate_i(gate),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .irq_o(irq));
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic check_bit(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED at %0t: flag %b expected %b", $time, g, e);
        end
    endtask
    // waitrequest and read data are taken at the rising edge, before its updates land
    // no wait limit here: only the bench timeout ends a stuck access
    task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        be <= b;
        if (w) begin
            wr <= 1'b1;
        end else begin
            rd <= 1'b1;
        end
        do begin
            @(posedge sys_clk_i);
        end while (waitreq !== 1'b0);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        access(1'b1, a, d, 4'hF);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        access(1'b0, a, 32'h0, 4'hF);
        check(got, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task automatic tick(input int which);
        @(posedge sys_clk_i);
        if (which == 0) begin
            t0_tick <= 1'b1;
        end else begin
            t1_tick <= 1'b1;
        end
        @(posedge sys_clk_i);
        t0_tick <= 1'b0;
        t1_tick <= 1'b0;
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    // both windows see identical register traffic and a 96-cycle burst, so their length matches
    task automatic window(input int pulses, input int half);
        wr_reg(ctrl0_offset, 32'h0);
        wr_reg(t1ctrl_offset, 32'h0000_00C7);
        wr_reg(t1count_offset, 32'h0);
        wr_reg(t0count_offset, 32'hFF);
        tick(0);
        idle(2);
        rd_chk(t1ctrl_offset, 32'h0000_00CF);
        osc.burst(pulses, half);
        wr_reg(t0count_offset, 32'hFF);
        tick(0);
        idle(4);
        rd_chk(t1ctrl_offset, 32'h0000_00C7);
        rd_chk(t1count_offset, 32'(pulses));
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd_chk(ctrl0_offset, ctrl0_reset);
        rd_chk(t1ctrl_offset, t1ctrl_reset);
        rd_chk(4'h2, 32'h0);
        check_bit(irq, 1'b0);
        done("reset");
        wr_reg(t1count_offset, 32'h0);
        wr_reg(t1ctrl_offset, 32'h0000_00C0);
        osc.burst(5, 2);
        idle(4);
        rd_chk(t1count_offset, 32'h0);
        wr_reg(t1ctrl_offset, 32'h0000_00C1);
        osc.burst(9, 2);
        idle(4);
        rd_chk(t1count_offset, 32'h9);
        wr_reg(t1ctrl_offset, 32'h0000_00C3);
        osc.burst(4, 2);
        idle(4);
        rd_chk(t1count_offset, 32'h9);
        @(posedge sys_clk_i);
        gate <= 1'b1;
        osc.burst(4, 2);
        idle(4);
        rd_chk(t1count_offset, 32'hD);
        wr_reg(t1ctrl_offset, 32'h0000_0041);
        osc.burst(3, 2);
        repeat (3) tick(1);
        idle(4);
        rd_chk(t1count_offset, 32'h10);
        done("timer1");
        wr_reg(t0count_offset, 32'h0);
        wr_reg(ctrl0_offset, 32'h1);
        osc.burst(7, 2);
        tick(0);
        idle(4);
        rd_chk(t0count_offset, 32'h7);
        wr_reg(ctrl0_offset, 32'h3);
        osc.burst(3, 2);
        tick(0);
        idle(4);
        rd_chk(t0count_offset, 32'h8);
        done("timer0");
        window(24, 2);
        nominal = got;
        window(12, 4);
        check_bit(got < ((got + nominal) >> 1) && ((got + nominal) >> 1) < nominal, 1'b1);
        done("window");
        rd_chk(ctrl0_offset, 32'h0005_0000);
        check_bit(irq, 1'b0);
        access(1'b1, ctrl0_offset, 32'h0400_0000, 4'h8);
        idle(2);
        check_bit(irq, 1'b1);
        access(1'b1, ctrl0_offset, 32'h0004_0000, 4'h4);
        idle(2);
        check_bit(irq, 1'b0);
        rd_chk(ctrl0_offset, 32'h0401_0000);
        wr_reg(t1ctrl_offset, 32'h0000_0041);
        wr_reg(t1count_offset, 32'h0000_FFFF);
        tick(1);
        idle(2);
        rd_chk(t1count_offset, 32'h0);
        rd_chk(ctrl0_offset, 32'h0403_0000);
        done("interrupt");
        close_out();
    end
endmodule
